// ===== verilog/umdsp_map.vh
`ifndef UMDSP_MAP_VH
`define UMDSP_MAP_VH
// ----------------------------------------
// modem control field positions
// ----------------------------------------
`define UMDSP_MCR_DTR_BIT 0
`define UMDSP_MCR_RTS_BIT 1
`define UMDSP_MCR_OUT1_BIT 2
`define UMDSP_MCR_OUT2_BIT 3
`define UMDSP_MCR_RESET 8'h00
// ----------------------------------------
// modem status field positions
// ----------------------------------------
`define UMDSP_MSR_DCTS_BIT 0
`define UMDSP_MSR_DDSR_BIT 1
`define UMDSP_MSR_TERI_BIT 2
`define UMDSP_MSR_DCD_BIT 3
`define UMDSP_MSR_CTS_BIT 4
`define UMDSP_MSR_DSR_BIT 5
`define UMDSP_MSR_RI_BIT 6
`define UMDSP_MSR_CD_BIT 7
`define UMDSP_MSR_RESET 8'h00
// ----------------------------------------
// irq enable field positions
// ----------------------------------------
`define UMDSP_IER_RXDATA_BIT 0
`define UMDSP_IER_TXEMPTY_BIT 1
`define UMDSP_IER_LINE_BIT 2
`define UMDSP_IER_MODEM_BIT 3
`define UMDSP_IER_RESET 8'h00
`endif

// ===== verilog/umdsp_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for a group of pin inputs
module umdsp_sync #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ===== verilog/umdsp_ready.v
`timescale 1ns/10ps
// active-low dma ready indicators from buffer fill levels
module umdsp_ready #(
  parameter CNT_W = 8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire fifo_en,
  input wire [CNT_W-1:0] rx_count,
  input wire [CNT_W-1:0] rx_trigger,
  input wire [CNT_W-1:0] tx_count,
  input wire [CNT_W-1:0] tx_depth,
  output reg receive_ready_indicator_n,
  output reg transmit_ready_indicator_n
);
  reg [CNT_W-1:0] rx_need;
  reg [CNT_W-1:0] tx_cap;
  reg next_rx_n;
  reg next_tx_n;

  always @* begin
    // without the fifo a single holding register stands in for it
    rx_need = fifo_en ? ((rx_trigger == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1}
                                                      : rx_trigger)
                      : {{(CNT_W-1){1'b0}}, 1'b1};
    tx_cap = fifo_en ? tx_depth : {{(CNT_W-1){1'b0}}, 1'b1};
    // low once data waits at or above the trigger level
    next_rx_n = !(rx_count >= rx_need);
    // low while any location is free
    next_tx_n = !(tx_count < tx_cap);
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      receive_ready_indicator_n <= 1'b1;
      transmit_ready_indicator_n <= 1'b0;
    end else begin
      receive_ready_indicator_n <= next_rx_n;
      transmit_ready_indicator_n <= next_tx_n;
    end
  end
endmodule

// ===== verilog/umdsp_chan.v
`timescale 1ns/10ps
`include "umdsp_map.vh"
// Notes on behaviour
// - each channel owns its pins, none shared
// - control bit 3 high: irq driven, output low
// - control bit 3 low: irq floats, output high
// - reset returns registers and outputs to defaults
// - reset holds serial out and in disabled
// - receive ready low when characters reach the trigger level (one without fifo)
// - transmit ready high when buffer full
// - clear-to-send shown in status bit 4
// - clear-to-send never gates transmit or receive
// - control bit 0 set drives terminal-ready low
// - terminal-ready high after bit 0 clear, reset
// - control bit 1 set drives request-to-send low
// - irq needs bit 3, enable and a condition
module umdsp_chan #(
  parameter CNT_W = 8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire mcr_we,
  input wire [7:0] mcr_wdata,
  input wire ier_we,
  input wire [7:0] ier_wdata,
  input wire msr_rd,
  input wire rx_data_avail,
  input wire tx_empty,
  input wire line_error,
  input wire fifo_en,
  input wire [CNT_W-1:0] rx_count,
  input wire [CNT_W-1:0] rx_trigger,
  input wire [CNT_W-1:0] tx_count,
  input wire [CNT_W-1:0] tx_depth,
  input wire tx_serial,
  input wire rx_pin,
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire cd_n,
  output reg [7:0] modem_control_reg,
  output reg [7:0] irq_enable_reg,
  output reg [7:0] modem_status_reg,
  output reg dtr_n,
  output reg rts_n,
  output reg user_general_output_n,
  output reg irq_out,
  output reg irq_oe,
  output reg tx_pin,
  output wire rx_serial,
  output wire receive_ready_indicator_n,
  output wire transmit_ready_indicator_n
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [3:0] modem_s;
  wire rx_s;
  reg [3:0] modem_prev;
  reg next_irq;
  reg modem_evt;

  // a delta bit is set by a pin change and held until a status read;
  // the change wins when both fall in one cycle so no event is lost
  function sticky_bit;
    input evt;
    input held;
    input clr;
    begin
      sticky_bit = evt | (held & ~clr);
    end
  endfunction

  // one instance per channel keeps all modem pins private
  umdsp_sync #(.WIDTH(4), .INIT(4'hf)) u_modem_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({cd_n, ri_n, dsr_n, cts_n}),
    .q(modem_s)
  );

  umdsp_sync #(.WIDTH(1), .INIT(1'b1)) u_rx_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d(rx_pin),
    .q(rx_s)
  );

  // receive path sees idle mark during reset
  assign rx_serial = sys_rst ? 1'b1 : rx_s;

  // ----------------------------------------
  // ready indicators
  // ----------------------------------------
  // ready pins are level status only; the dma controller paces on them
  umdsp_ready #(.CNT_W(CNT_W)) u_ready (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .fifo_en(fifo_en),
    .rx_count(rx_count),
    .rx_trigger(rx_trigger),
    .tx_count(tx_count),
    .tx_depth(tx_depth),
    .receive_ready_indicator_n(receive_ready_indicator_n),
    .transmit_ready_indicator_n(transmit_ready_indicator_n)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      modem_control_reg <= `UMDSP_MCR_RESET;
      irq_enable_reg <= `UMDSP_IER_RESET;
    end else begin
      if (mcr_we) begin
        modem_control_reg <= mcr_wdata;
      end
      if (ier_we) begin
        irq_enable_reg <= ier_wdata;
      end
    end
  end

  // ----------------------------------------
  // modem outputs
  // ----------------------------------------
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_general_output_n <= 1'b1;
      tx_pin <= 1'b1;
    end else begin
      dtr_n <= ~modem_control_reg[`UMDSP_MCR_DTR_BIT];
      rts_n <= ~modem_control_reg[`UMDSP_MCR_RTS_BIT];
      user_general_output_n <= ~modem_control_reg[`UMDSP_MCR_OUT2_BIT];
      // cts is not consulted here; transmit runs regardless
      tx_pin <= tx_serial;
    end
  end

  // ----------------------------------------
  // modem status
  // ----------------------------------------
  // delta bits are sticky; a change in the read cycle wins over the clear
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      modem_status_reg <= `UMDSP_MSR_RESET;
      modem_prev <= 4'hf;
    end else begin
      modem_prev <= modem_s;
      modem_status_reg[`UMDSP_MSR_CTS_BIT] <= ~modem_s[0];
      modem_status_reg[`UMDSP_MSR_DSR_BIT] <= ~modem_s[1];
      modem_status_reg[`UMDSP_MSR_RI_BIT] <= ~modem_s[2];
      modem_status_reg[`UMDSP_MSR_CD_BIT] <= ~modem_s[3];
      modem_status_reg[`UMDSP_MSR_DCTS_BIT] <= sticky_bit(modem_s[0] ^ modem_prev[0],
        modem_status_reg[`UMDSP_MSR_DCTS_BIT], msr_rd);
      modem_status_reg[`UMDSP_MSR_DDSR_BIT] <= sticky_bit(modem_s[1] ^ modem_prev[1],
        modem_status_reg[`UMDSP_MSR_DDSR_BIT], msr_rd);
      // ring end: pin rising back to one
      modem_status_reg[`UMDSP_MSR_TERI_BIT] <= sticky_bit(modem_s[2] & ~modem_prev[2],
        modem_status_reg[`UMDSP_MSR_TERI_BIT], msr_rd);
      modem_status_reg[`UMDSP_MSR_DCD_BIT] <= sticky_bit(modem_s[3] ^ modem_prev[3],
        modem_status_reg[`UMDSP_MSR_DCD_BIT], msr_rd);
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  always @* begin
    modem_evt = modem_status_reg[`UMDSP_MSR_DCTS_BIT] | modem_status_reg[`UMDSP_MSR_DDSR_BIT] |
                modem_status_reg[`UMDSP_MSR_TERI_BIT] | modem_status_reg[`UMDSP_MSR_DCD_BIT];
    next_irq = (irq_enable_reg[`UMDSP_IER_RXDATA_BIT] & rx_data_avail) |
               (irq_enable_reg[`UMDSP_IER_TXEMPTY_BIT] & tx_empty) |
               (irq_enable_reg[`UMDSP_IER_LINE_BIT] & line_error) |
               (irq_enable_reg[`UMDSP_IER_MODEM_BIT] & modem_evt);
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      // bit 3 both enables the driver and gates the request
      irq_oe <= modem_control_reg[`UMDSP_MCR_OUT2_BIT];
      irq_out <= modem_control_reg[`UMDSP_MCR_OUT2_BIT] & next_irq;
    end
  end
endmodule

// ===== tb/umdsp_chan_assertions.sv
`timescale 1ns/10ps
module umdsp_chk #(
  parameter CNT_W = 8
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire mcr_we,
  input wire [7:0] mcr_wdata,
  input wire fifo_en,
  input wire [CNT_W-1:0] rx_count,
  input wire [CNT_W-1:0] rx_trigger,
  input wire [CNT_W-1:0] tx_count,
  input wire [CNT_W-1:0] tx_depth,
  input wire cts_n,
  input wire [7:0] modem_status_reg,
  input wire dtr_n,
  input wire rts_n,
  input wire user_general_output_n,
  input wire irq_out,
  input wire irq_oe,
  input wire tx_pin,
  input wire rx_serial,
  input wire receive_ready_indicator_n,
  input wire transmit_ready_indicator_n
);
  // a zero trigger would mean ready with an empty buffer, so it counts as one
  wire rx_hit = rx_count >= ((fifo_en && rx_trigger != 0) ? rx_trigger : CNT_W'(1));
  wire tx_hit = tx_count < (fifo_en ? tx_depth : CNT_W'(1));
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_dtr_follow:
    assert property (mcr_we |-> ##2 dtr_n == !$past(mcr_wdata[0], 2)) else $error("dtr");
  a_rts_follow:
    assert property (mcr_we |-> ##2 rts_n == !$past(mcr_wdata[1], 2)) else $error("rts");
  a_op_irq_gate:
    assert property (mcr_we |-> ##2 irq_oe == $past(mcr_wdata[3], 2) &&
      user_general_output_n == !irq_oe) else $error("op gate");
  a_irq_needs_oe:
    assert property (irq_out |-> irq_oe) else $error("irq undriven");
  a_rx_ready:
    assert property (!$past(sys_rst) |-> receive_ready_indicator_n == !$past(rx_hit))
      else $error("rx ready");
  a_tx_ready:
    assert property (!$past(sys_rst) |-> transmit_ready_indicator_n == !$past(tx_hit))
      else $error("tx ready");
  a_cts_status:
    assert property ($changed(cts_n) |-> ##3 modem_status_reg[4] != $past(cts_n, 3))
      else $error("cts status");
  a_reset_pins:
    assert property (disable iff (1'b0) sys_rst |-> dtr_n && rts_n && user_general_output_n
      && tx_pin && rx_serial && !irq_oe && !irq_out) else $error("reset pins");
endmodule
bind umdsp_chan umdsp_chk #(.CNT_W(CNT_W)) chk (.*);

// ===== tb/umdsp_modem.sv
`timescale 1ns/10ps
module umdsp_modem #(
  parameter LAG = 2
) (
  input wire clk_sys,
  input wire rts_n,
  input wire dtr_n,
  input wire [3:0] cmd,
  output reg cts_n,
  output reg dsr_n,
  output reg ri_n,
  output reg cd_n,
  output wire rx_pin
);
  // status lines answer late, as a slow data set would
  reg [3:0] cnt = 4'h0;
  wire [3:0] want_n = ~(cmd & {2'h3, !dtr_n, !rts_n});
  initial {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
  always @(negedge clk_sys) begin
    if (want_n == {cd_n, ri_n, dsr_n, cts_n}) cnt <= 4'h0;
    else if (cnt < LAG) cnt <= cnt + 4'h1;
    else {cd_n, ri_n, dsr_n, cts_n} <= want_n;
  end
  // no frames here: the receive line rests at mark unless the bench pulls it low
  assign rx_pin = ~cmd[2];
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  reg clk_sys, sys_rst, mcr_we, ier_we, msr_rd, rx_data_avail, tx_empty, line_error;
  reg fifo_en, tx_serial;
  reg [7:0] mcr_wdata, ier_wdata, rx_count, rx_trigger, tx_count, tx_depth, d;
  reg [3:0] cmd;
  reg [1:0] rdy;
  reg [31:0] seed;
  wire cts_n, dsr_n, ri_n, cd_n, rx_pin, dtr_n, rts_n, user_general_output_n, irq_out, irq_oe;
  wire tx_pin, rx_serial, receive_ready_indicator_n, transmit_ready_indicator_n;
  wire [7:0] modem_control_reg, irq_enable_reg, modem_status_reg;
  integer fail_count, compares, i;
  umdsp_chan #(.CNT_W(8)) DUT (.*);
  umdsp_modem #(.LAG(2)) modem (.*);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  function [31:0] rnd(input [31:0] s);
    rnd = s ^ (s << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  endfunction
  function [1:0] rdy_n(input f, input [7:0] rc, rt, tc, td);
    rdy_n[1] = !(rc >= ((f && rt != 0) ? rt : 8'h1));
    rdy_n[0] = !(tc < (f ? td : 8'h1));
  endfunction
  task chk(input [7:0] seen, input [7:0] exp, input [8*6:1] what);
    compares = compares + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task chk_rst;
    chk(dtr_n, 1, "dtr");
    chk(rts_n, 1, "rts");
    chk(user_general_output_n, 1, "op");
    chk(irq_oe, 0, "irq_oe");
    chk(tx_pin, 1, "tx");
    chk(rx_serial, 1, "rx");
    chk(modem_control_reg, 0, "mcr");
    chk(transmit_ready_indicator_n, 0, "txrdy");
    chk(receive_ready_indicator_n, 1, "rxrdy");
    chk(irq_out, 0, "irq");
  endtask
  task stop_test;
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // about four times the planned run
  initial begin
    #6000;
    fail_count = fail_count + 1;
    stop_test;
  end
  initial begin
    fail_count = 0;
    compares = 0;
    seed = 32'h64f7;
    {mcr_we, ier_we, msr_rd, rx_data_avail, tx_empty, line_error, fifo_en} = 7'h0;
    // non-blocking so the reset edge is seen by every process started at time zero
    sys_rst <= 1'h1;
    {mcr_wdata, ier_wdata, rx_count, rx_trigger, tx_count, tx_depth} = 48'h0;
    cmd = 4'h0;
    tx_serial = 1'h1;
    repeat (8) @(negedge clk_sys);
    chk_rst;
    sys_rst = 1'h0;
    for (i = 0; i < 48; i = i + 1) begin
      seed = rnd(seed);
      d = (i == 0) ? 8'h0b : seed[7:0];
      mcr_wdata = d;
      ier_wdata = {5'h0, seed[10:8]};
      {mcr_we, ier_we, msr_rd} = {2'h3, seed[11]};
      {fifo_en, rx_data_avail, tx_empty, line_error} = seed[15:12];
      cmd = seed[19:16];
      rx_trigger = seed[27:20];
      // counts sit near the thresholds so both sides of each edge get hit
      rx_count = rx_trigger + seed[29:28] - 8'h2;
      tx_depth = {2'h0, seed[31:30], seed[3:0]};
      tx_count = tx_depth - seed[9:8];
      rdy = rdy_n(fifo_en, rx_count, rx_trigger, tx_count, tx_depth);
      @(negedge clk_sys);
      {mcr_we, ier_we, msr_rd} = 3'h0;
      @(negedge clk_sys);
      chk(dtr_n, !d[0], "dtr");
      chk(rts_n, !d[1], "rts");
      chk(user_general_output_n, !d[3], "op");
      chk(irq_oe, d[3], "irq_oe");
      chk(irq_out, d[3] & |(ier_wdata[2:0] & {line_error, tx_empty, rx_data_avail}), "irq");
      chk(receive_ready_indicator_n, rdy[1], "rxrdy");
      chk(transmit_ready_indicator_n, rdy[0], "txrdy");
      chk(modem_control_reg, d, "mcr");
      chk(irq_enable_reg, ier_wdata, "ier");
    end
    mcr_wdata = 8'h02;
    mcr_we = 1'h1;
    @(negedge clk_sys);
    mcr_we = 1'h0;
    for (i = 0; i < 2; i = i + 1) begin
      cmd = {3'h0, !i[0]};
      repeat (12) @(negedge clk_sys);
      chk(modem_status_reg[4], !i[0], "cts");
      tx_serial = i[0];
      @(negedge clk_sys);
      chk(tx_pin, i[0], "tx");
    end
    // modem interrupt source: clear old deltas, then a cts change must raise the request
    mcr_wdata = 8'h0a;
    ier_wdata = 8'h08;
    {mcr_we, ier_we, msr_rd} = 3'h7;
    @(negedge clk_sys);
    {mcr_we, ier_we, msr_rd} = 3'h0;
    repeat (2) @(negedge clk_sys);
    chk(irq_out, 0, "irq");
    cmd = 4'h1;
    repeat (12) @(negedge clk_sys);
    chk(modem_status_reg[0], 1, "dcts");
    chk(irq_out, 1, "irq");
    // receive pin low, so reset must visibly force the receive path to mark
    cmd = 4'h4;
    repeat (3) @(negedge clk_sys);
    chk(rx_serial, 0, "rx");
    sys_rst = 1'h1;
    @(negedge clk_sys);
    chk_rst;
    sys_rst = 1'h0;
    @(negedge clk_sys);
    stop_test;
  end
endmodule
